// ===== cvrf_pkg.sv
package cvrf_pkg;
	// flag register bit positions
	localparam int unsigned FLAG_C  = 0;
	localparam int unsigned FLAG_N  = 1;
	localparam int unsigned FLAG_PV = 2;
	localparam int unsigned FLAG_U3 = 3;
	localparam int unsigned FLAG_H  = 4;
	localparam int unsigned FLAG_U5 = 5;
	localparam int unsigned FLAG_Z  = 6;
	localparam int unsigned FLAG_S  = 7;

	// reset values
	localparam logic [7:0]  FLAGS_RESET = 8'h00;
	localparam logic [7:0]  PAGE_RESET  = 8'h00;
	localparam logic [7:0]  RFSH_RESET  = 8'h00;
	localparam logic [15:0] IM1_VECTOR  = 16'h0038;

	// unprefixed opcodes
	localparam logic [7:0] OP_PREFIX_ED = 8'hED;
	localparam logic [7:0] OP_EI        = 8'hFB;
	localparam logic [7:0] OP_DI        = 8'hF3;
	localparam logic [7:0] OP_SCF       = 8'h37;
	localparam logic [7:0] OP_CCF       = 8'h3F;
	localparam logic [7:0] OP_DAA       = 8'h27;
	localparam logic [7:0] OP_POP_AF    = 8'hF1;

	// second bytes after the extended prefix
	localparam logic [7:0] ED_NEG      = 8'h44;
	localparam logic [7:0] ED_IM0      = 8'h46;
	localparam logic [7:0] ED_IM1      = 8'h56;
	localparam logic [7:0] ED_IM2      = 8'h5E;
	localparam logic [7:0] ED_LD_I_A   = 8'h47;
	localparam logic [7:0] ED_LD_R_A   = 8'h4F;
	localparam logic [7:0] ED_LD_A_I   = 8'h57;
	localparam logic [7:0] ED_LD_A_R   = 8'h5F;

	// cycles from acknowledge to sampling the synchronised vector byte
	localparam logic [1:0] ACK_SETTLE = 2'h3;

	typedef enum logic [1:0] {
		CVRF_IM0 = 2'b00,
		CVRF_IM1 = 2'b01,
		CVRF_IM2 = 2'b10
	} cvrf_im_e;

	typedef enum logic [2:0] {
		CVRF_FK_KEEP   = 3'b000,
		CVRF_FK_LOGIC  = 3'b001,
		CVRF_FK_ARITH  = 3'b010,
		CVRF_FK_INCDEC = 3'b011,
		CVRF_FK_SETC   = 3'b100,
		CVRF_FK_CPLC   = 3'b101,
		CVRF_FK_IREAD  = 3'b110
	} cvrf_fkind_e;

	typedef enum logic [1:0] {
		CVRF_ST_IDLE   = 2'b00,
		CVRF_ST_ACK    = 2'b01,
		CVRF_ST_LAUNCH = 2'b10
	} cvrf_state_e;
endpackage

// ===== cvrf_flag_unit.sv
`timescale 1ns/100ps
module cvrf_flag_unit
	import cvrf_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        apply,
	input  cvrf_fkind_e      kind,
	input  wire logic        sub_op,
	input  wire logic [7:0]  result,
	input  wire logic        carry,
	input  wire logic        half,
	input  wire logic        ovf,
	input  wire logic        ie_state,
	input  wire logic        load_valid,
	input  wire logic [7:0]  load_data,
	output logic      [7:0]  flags_reg
);
	logic [7:0] flags_next;
	logic [7:0] calc;
	logic       parity;

	assign parity = ~^result;

	////////////////////////////////////////////////////////////////////////
	// flag computation per class
	always_comb begin
		calc = flags_reg;
		calc[FLAG_S]  = result[7];
		calc[FLAG_Z]  = (result == 8'h00);
		calc[FLAG_U5] = result[5];
		calc[FLAG_U3] = result[3];
		unique case (kind)
			CVRF_FK_LOGIC: begin
				calc[FLAG_PV] = parity;
				calc[FLAG_H]  = half;
				calc[FLAG_N]  = 1'b0;
				calc[FLAG_C]  = carry;
			end
			CVRF_FK_ARITH: begin
				calc[FLAG_PV] = ovf;
				calc[FLAG_H]  = half;
				calc[FLAG_N]  = sub_op;
				calc[FLAG_C]  = carry;
			end
			CVRF_FK_INCDEC: begin
				calc[FLAG_PV] = ovf;
				calc[FLAG_H]  = half;
				calc[FLAG_N]  = sub_op;
			end
			CVRF_FK_IREAD: begin
				calc[FLAG_PV] = ie_state;
				calc[FLAG_H]  = 1'b0;
				calc[FLAG_N]  = 1'b0;
			end
			CVRF_FK_SETC: begin
				calc        = flags_reg;
				calc[FLAG_H] = 1'b0;
				calc[FLAG_N] = 1'b0;
				calc[FLAG_C] = 1'b1;
			end
			CVRF_FK_CPLC: begin
				calc         = flags_reg;
				calc[FLAG_H] = flags_reg[FLAG_C];
				calc[FLAG_N] = 1'b0;
				calc[FLAG_C] = ~flags_reg[FLAG_C];
			end
			CVRF_FK_KEEP: begin
				calc = flags_reg;
			end
			default: begin
				calc = flags_reg;
			end
		endcase
	end

	assign flags_next = load_valid ? load_data :
	                    apply      ? calc      :
	                                 flags_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flags_reg <= FLAGS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end
endmodule

// ===== cvrf_core.sv
`timescale 1ns/100ps
// Overview of operation
// - mode 2 vector is page byte then line byte
// - eight-bit refresh register gives refresh row
// - refresh strobe with address on opcode fetch
// - bit 2 parity for logic, overflow for arithmetic
// - reset enters legacy mode; extensions need explicit opcodes
// - every legacy opcode accepted with same meaning
// - unlisted instructions leave all flags unchanged
// - pushed flag bits 3, 5 unspecified
// - mode 1 restarts at fixed vector, no byte
module cvrf_core
	import cvrf_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        op_valid,
	input  wire logic [7:0]  op_byte,
	input  wire logic        exec_done,
	input  wire logic [7:0]  alu_result,
	input  wire logic        alu_carry,
	input  wire logic        alu_half,
	input  wire logic        alu_ovf,
	input  wire logic [7:0]  acc_value,
	input  wire logic        pop_flags_valid,
	input  wire logic [7:0]  pop_flags,
	input  wire logic        int_req_n,
	input  wire logic [7:0]  int_line_pin,
	output logic             refresh_strobe,
	output logic      [7:0]  refresh_addr,
	output logic             legacy_op,
	output logic             int_ack,
	output logic             irq_taken,
	output logic             irq_indirect,
	output logic      [15:0] irq_vector_addr,
	output logic             im0_byte_valid,
	output logic      [7:0]  im0_byte,
	output logic             special_read_valid,
	output logic      [7:0]  special_read_data,
	output logic      [7:0]  flags,
	output logic      [1:0]  int_mode,
	output logic      [7:0]  int_page,
	output logic             int_enable
);
	////////////////////////////////////////////////////////////////////////
	// decode helpers
	function automatic cvrf_fkind_e flag_kind_f(input logic ext,
	                                            input logic [7:0] op);
		cvrf_fkind_e k;
		k = CVRF_FK_KEEP;
		if (ext) begin
			if (op == ED_NEG)
				k = CVRF_FK_ARITH;
			else if (op == ED_LD_A_I || op == ED_LD_A_R)
				k = CVRF_FK_IREAD;
		end else begin
			if (op[7:6] == 2'b10 ||
			    (op[7:6] == 2'b11 && op[2:0] == 3'h6))
				k = (op[5:3] >= 3'h4 && op[5:3] <= 3'h6) ?
				    CVRF_FK_LOGIC : CVRF_FK_ARITH;
			else if (op[7:6] == 2'b00 && op[2:1] == 2'b10)
				k = CVRF_FK_INCDEC;
			else if (op == OP_SCF)
				k = CVRF_FK_SETC;
			else if (op == OP_CCF)
				k = CVRF_FK_CPLC;
			else if (op == OP_DAA)
				k = CVRF_FK_LOGIC;
		end
		return k;
	endfunction
	function automatic logic sub_f(input logic ext, input logic [7:0] op);
		return ext || ((op[7:6] == 2'b00) ? op[0] : op[4]);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic       req_n_meta_reg;
	logic       req_n_sync_reg;
	logic [7:0] line_meta_reg;
	logic [7:0] line_sync_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			req_n_meta_reg <= 1'b1;
			req_n_sync_reg <= 1'b1;
			line_meta_reg  <= 8'h00;
			line_sync_reg  <= 8'h00;
		end else begin
			req_n_meta_reg <= int_req_n;
			req_n_sync_reg <= req_n_meta_reg;
			line_meta_reg  <= int_line_pin;
			line_sync_reg  <= line_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// opcode decode
	logic        ext_reg;
	logic        ext_next;
	logic        is_prefix;
	logic        ext_op;
	logic        base_op;
	logic        do_im0;
	logic        do_im1;
	logic        do_im2;
	logic        do_ld_i;
	logic        do_ld_r;
	logic        do_rd_i;
	logic        do_rd_r;
	logic        do_ei;
	logic        do_di;
	cvrf_fkind_e kind_reg;
	logic        sub_reg;

	assign is_prefix = op_valid && !ext_reg && op_byte == OP_PREFIX_ED;
	assign ext_op    = op_valid && ext_reg;
	assign base_op   = op_valid && !ext_reg && !is_prefix;
	assign ext_next  = op_valid ? is_prefix : ext_reg;
	assign do_im0    = ext_op && op_byte == ED_IM0;
	assign do_im1    = ext_op && op_byte == ED_IM1;
	assign do_im2    = ext_op && op_byte == ED_IM2;
	assign do_ld_i   = ext_op && op_byte == ED_LD_I_A;
	assign do_ld_r   = ext_op && op_byte == ED_LD_R_A;
	assign do_rd_i   = ext_op && op_byte == ED_LD_A_I;
	assign do_rd_r   = ext_op && op_byte == ED_LD_A_R;
	assign do_ei     = base_op && op_byte == OP_EI;
	assign do_di     = base_op && op_byte == OP_DI;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ext_reg  <= 1'b0;
			kind_reg <= CVRF_FK_KEEP;
			sub_reg  <= 1'b0;
		end else begin
			ext_reg <= ext_next;
			if (base_op || ext_op) begin
				kind_reg <= flag_kind_f(ext_reg, op_byte);
				sub_reg  <= sub_f(ext_reg, op_byte);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			legacy_op <= 1'b0;
		end else begin
			legacy_op <= base_op;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// refresh register
	logic [7:0] rfsh_reg;
	logic [7:0] rfsh_next;

	assign rfsh_next = do_ld_r  ? acc_value :
	                   op_valid ? rfsh_reg + 8'h01 :
	                              rfsh_reg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rfsh_reg       <= RFSH_RESET;
			refresh_strobe <= 1'b0;
			refresh_addr   <= RFSH_RESET;
		end else begin
			rfsh_reg       <= rfsh_next;
			refresh_strobe <= op_valid;
			if (op_valid)
				refresh_addr <= rfsh_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode, page, enable, special reads
	cvrf_im_e   im_reg;
	logic [7:0] page_reg;
	logic       ie_reg;
	logic       take;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			im_reg   <= CVRF_IM0;
			page_reg <= PAGE_RESET;
			ie_reg   <= 1'b0;
		end else begin
			if (do_im0)
				im_reg <= CVRF_IM0;
			else if (do_im1)
				im_reg <= CVRF_IM1;
			else if (do_im2)
				im_reg <= CVRF_IM2;
			if (do_ld_i)
				page_reg <= acc_value;
			if (take || do_di)
				ie_reg <= 1'b0;
			else if (do_ei)
				ie_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			special_read_valid <= 1'b0;
			special_read_data  <= 8'h00;
		end else begin
			special_read_valid <= do_rd_i || do_rd_r;
			if (do_rd_i)
				special_read_data <= page_reg;
			else if (do_rd_r)
				special_read_data <= rfsh_reg;
		end
	end

	assign int_mode   = im_reg;
	assign int_page   = page_reg;
	assign int_enable = ie_reg;

	////////////////////////////////////////////////////////////////////////
	// interrupt sequencer
	cvrf_state_e state_reg;
	cvrf_state_e state_next;
	logic [1:0]  cnt_reg;
	logic        settled;

	assign take    = state_reg == CVRF_ST_IDLE && !req_n_sync_reg &&
	                 ie_reg && !ext_reg && !op_valid;
	assign settled = state_reg == CVRF_ST_ACK && cnt_reg == ACK_SETTLE;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CVRF_ST_IDLE: begin
				if (take)
					state_next = (im_reg == CVRF_IM1) ?
					             CVRF_ST_LAUNCH : CVRF_ST_ACK;
			end
			CVRF_ST_ACK:
				state_next = settled ? CVRF_ST_LAUNCH : state_reg;
			CVRF_ST_LAUNCH:
				state_next = CVRF_ST_IDLE;
			default:
				state_next = CVRF_ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg       <= CVRF_ST_IDLE;
			cnt_reg         <= 2'h0;
			irq_vector_addr <= 16'h0000;
			irq_indirect    <= 1'b0;
			im0_byte        <= 8'h00;
			im0_byte_valid  <= 1'b0;
		end else begin
			state_reg      <= state_next;
			im0_byte_valid <= 1'b0;
			cnt_reg <= (state_reg == CVRF_ST_ACK) ? cnt_reg + 2'h1 : 2'h0;
			if (take && im_reg == CVRF_IM1) begin
				irq_vector_addr <= IM1_VECTOR;
				irq_indirect    <= 1'b0;
			end
			if (settled) begin
				if (im_reg == CVRF_IM2) begin
					irq_vector_addr <= {page_reg, line_sync_reg};
					irq_indirect    <= 1'b1;
				end else begin
					im0_byte       <= line_sync_reg;
					im0_byte_valid <= 1'b1;
					irq_vector_addr <= 16'h0000;
					irq_indirect    <= 1'b0;
				end
			end
		end
	end

	assign int_ack   = state_reg == CVRF_ST_ACK;
	assign irq_taken = state_reg == CVRF_ST_LAUNCH;

	////////////////////////////////////////////////////////////////////////
	// flag register
	cvrf_flag_unit cvrf_flag_unit_i (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.apply      (exec_done),
		.kind       (kind_reg),
		.sub_op     (sub_reg),
		.result     (alu_result),
		.carry      (alu_carry),
		.half       (alu_half),
		.ovf        (alu_ovf),
		.ie_state   (ie_reg),
		.load_valid (pop_flags_valid),
		.load_data  (pop_flags),
		.flags_reg  (flags)
	);
endmodule

// ===== cvrf_core_asserts.sv
`timescale 1ns/100ps
module cvrf_core_asserts
	import cvrf_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        op_valid,
	input wire logic [7:0]  op_byte,
	input wire logic        exec_done,
	input wire logic [7:0]  alu_result,
	input wire logic        alu_ovf,
	input wire logic        pop_flags_valid,
	input wire logic [7:0]  int_line_pin,
	input wire logic        refresh_strobe,
	input wire logic [7:0]  refresh_addr,
	input wire logic        legacy_op,
	input wire logic        int_ack,
	input wire logic        irq_taken,
	input wire logic        irq_indirect,
	input wire logic [15:0] irq_vector_addr,
	input wire logic [7:0]  flags,
	input wire logic [1:0]  int_mode,
	input wire logic [7:0]  int_page
);
	logic [7:0] last_op_reg;
	logic       last_ed_reg;
	logic       pfx_reg;
	logic       fl_upd;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// track prefix state and last decoded opcode
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pfx_reg     <= 1'b0;
			last_ed_reg <= 1'b0;
			last_op_reg <= 8'h00;
		end else if (op_valid) begin
			pfx_reg     <= (op_byte == OP_PREFIX_ED) && !pfx_reg;
			last_ed_reg <= pfx_reg;
			last_op_reg <= op_byte;
		end
	end
	assign fl_upd = exec_done && !pop_flags_valid && !last_ed_reg;
	property p_rfsh; op_valid |=> refresh_strobe; endproperty
	a_rfsh: assert property (p_rfsh) else $error("no strobe");
	property p_radv; op_valid && !(pfx_reg && op_byte == ED_LD_R_A) ##1
		op_valid |=> refresh_addr == $past(refresh_addr) + 8'h01; endproperty
	a_radv: assert property (p_radv) else $error("row stuck");
	property p_legacy; op_valid && !pfx_reg && op_byte != OP_PREFIX_ED
		|=> legacy_op; endproperty
	a_legacy: assert property (p_legacy) else $error("no legacy");
	property p_im1; irq_taken && int_mode == CVRF_IM1
		|-> !irq_indirect && irq_vector_addr == IM1_VECTOR; endproperty
	a_im1: assert property (p_im1) else $error("bad mode 1");
	property p_im2; irq_taken && int_mode == CVRF_IM2
		|-> irq_indirect && irq_vector_addr[15:8] == int_page; endproperty
	a_im2: assert property (p_im2) else $error("bad page");
	property p_ack; $rose(int_ack) && int_mode == CVRF_IM2 |-> int_ack[*4]
		##1 (!int_ack && irq_taken
		&& irq_vector_addr[7:0] == $past(int_line_pin, 2)); endproperty
	a_ack: assert property (p_ack) else $error("bad line");
	property p_arith; fl_upd && last_op_reg[7:5] == 3'b100
		|=> flags[FLAG_PV] == $past(alu_ovf); endproperty
	a_arith: assert property (p_arith) else $error("bad ovf");
	property p_logic; fl_upd && last_op_reg inside {[8'hA0:8'hB7]}
		|=> flags[FLAG_PV] == ~^$past(alu_result); endproperty
	a_logic: assert property (p_logic) else $error("bad par");
	c_im1: cover property (irq_taken && !irq_indirect);
	c_im2: cover property (irq_taken && irq_indirect);
	c_rld: cover property (op_valid && pfx_reg && op_byte == ED_LD_R_A);
endmodule
bind cvrf_core cvrf_core_asserts cvrf_core_asserts_i (.sys_clk, .rst_n,
	.op_valid, .op_byte, .exec_done, .alu_result, .alu_ovf, .pop_flags_valid,
	.int_line_pin, .refresh_strobe, .refresh_addr, .legacy_op, .int_ack,
	.irq_taken, .irq_indirect, .irq_vector_addr, .flags, .int_mode, .int_page);

// ===== cvrf_periph_model.sv
`timescale 1ns/100ps
module cvrf_periph_model
	import cvrf_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       raise,
	input  wire logic [7:0] vec,
	input  wire logic       int_ack,
	input  wire logic       irq_taken,
	output logic            int_req_n,
	output logic      [7:0] int_line_pin
);
	logic pend_reg;
	// request held until the core takes it
	always_ff @(posedge sys_clk) begin
		if (!rst_n) pend_reg <= 1'b0;
		else if (raise) pend_reg <= 1'b1;
		else if (irq_taken) pend_reg <= 1'b0;
	end
	assign int_req_n    = ~pend_reg;
	// byte only while acknowledged, inverse otherwise
	assign int_line_pin = int_ack ? vec : ~vec;
endmodule

// ===== cvrf_core_bench.sv
`timescale 1ns/100ps
module cvrf_core_bench
	import cvrf_pkg::*;
;
	logic        sys_clk, rst_n, op_valid, exec_done, alu_ovf, raise;
	logic        pop_flags_valid, int_req_n, refresh_strobe, legacy_op;
	logic        int_ack, irq_taken, irq_indirect, int_enable;
	logic [7:0]  op_byte, alu_result, acc_value, pop_flags, vec;
	logic [7:0]  int_line_pin, refresh_addr, flags, int_page;
	logic [15:0] irq_vector_addr, acks;
	logic [1:0]  int_mode;
	logic        im0_byte_valid, special_read_valid;
	logic [7:0]  im0_byte, special_read_data;
	int          mismatches, cmp_count;
	cvrf_core cvrf_core_i (.sys_clk, .rst_n, .op_valid, .op_byte, .exec_done,
		.alu_result, .alu_carry(1'b0), .alu_half(1'b0), .alu_ovf, .acc_value,
		.pop_flags_valid, .pop_flags, .int_req_n, .int_line_pin,
		.refresh_strobe, .refresh_addr, .legacy_op, .int_ack, .irq_taken,
		.irq_indirect, .irq_vector_addr, .im0_byte_valid, .im0_byte,
		.special_read_valid, .special_read_data, .flags, .int_mode,
		.int_page, .int_enable);
	cvrf_periph_model cvrf_periph_model_i (.sys_clk, .rst_n, .raise, .vec,
		.int_ack, .irq_taken, .int_req_n, .int_line_pin);
	////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [15:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task fetch(input logic [7:0] b);
		@(posedge sys_clk);
		op_valid <= 1'b1;
		op_byte  <= b;
	endtask
	task idle;
		@(posedge sys_clk);
		op_valid <= 1'b0;
	endtask
	task exec(input logic [7:0] res, input logic ovf);
		@(posedge sys_clk);
		exec_done  <= 1'b1;
		alu_result <= res;
		alu_ovf    <= ovf;
		@(posedge sys_clk);
		exec_done <= 1'b0;
		#1;
	endtask
	task irq(input logic [7:0] v);
		@(posedge sys_clk);
		raise <= 1'b1;
		vec   <= v;
		@(posedge sys_clk);
		raise <= 1'b0;
		acks = 16'h0000;
		for (int i = 0; i < 40 && irq_taken !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
			if (int_ack === 1'b1) acks++;
		end
		chk("taken", 1'b1, irq_taken);
		chk("enable", 1'b0, int_enable);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		#1;
		chk("flags", FLAGS_RESET, flags);
		chk("mode", CVRF_IM0, int_mode);
		chk("page", PAGE_RESET, int_page);
		chk("enable", 1'b0, int_enable);
	endtask
	task t_refresh;
		fetch(8'h3C);
		fetch(OP_PREFIX_ED);
		#1;
		chk("strobe", 1'b1, refresh_strobe);
		chk("row", RFSH_RESET, refresh_addr);
		chk("legacy", 1'b1, legacy_op);
		fetch(ED_LD_R_A);
		#1;
		chk("row", RFSH_RESET + 8'h01, refresh_addr);
		chk("legacy", 1'b0, legacy_op);
		idle;
		#1;
		chk("row", RFSH_RESET + 8'h02, refresh_addr);
		idle;
		#1;
		chk("strobe", 1'b0, refresh_strobe);
		fetch(8'h00);
		idle;
		#1;
		chk("row", 8'h5A, refresh_addr);
	endtask
	task t_flags;
		fetch(8'h80);
		idle;
		exec(8'h01, 1'b1);
		chk("pv", 1'b1, flags[FLAG_PV]);
		fetch(8'hA0);
		idle;
		exec(8'h03, 1'b1);
		chk("pv", 1'b1, flags[FLAG_PV]);
		fetch(8'hA8);
		idle;
		exec(8'h01, 1'b1);
		chk("pv", 1'b0, flags[FLAG_PV]);
		@(posedge sys_clk);
		pop_flags_valid <= 1'b1;
		pop_flags       <= 8'hD7;
		@(posedge sys_clk);
		pop_flags_valid <= 1'b0;
		#1;
		chk("flags", 8'hD7, flags);
		fetch(8'h00);
		idle;
		exec(8'hFF, 1'b1);
		chk("flags", 8'hD7, flags);
		fetch(OP_SCF);
		idle;
		exec(8'h00, 1'b0);
		chk("flags", 8'hC5, flags);
		fetch(OP_CCF);
		idle;
		exec(8'h00, 1'b0);
		chk("flags", 8'hD4, flags);
		fetch(8'h3C);
		idle;
		exec(8'h80, 1'b1);
		chk("pv", 1'b1, flags[FLAG_PV]);
		chk("carry", 1'b0, flags[FLAG_C]);
	endtask
	task t_int;
		fetch(OP_EI);
		idle;
		irq(8'hC7);
		chk("im0valid", 1'b1, im0_byte_valid);
		chk("im0byte", 8'hC7, im0_byte);
		chk("acks", 16'h0004, acks);
		chk("indirect", 1'b0, irq_indirect);
		fetch(OP_PREFIX_ED);
		fetch(ED_IM1);
		fetch(OP_EI);
		idle;
		#1;
		chk("mode", CVRF_IM1, int_mode);
		irq(8'h3C);
		chk("addr", IM1_VECTOR, irq_vector_addr);
		chk("indirect", 1'b0, irq_indirect);
		chk("acks", 16'h0000, acks);
		fetch(OP_PREFIX_ED);
		fetch(ED_LD_I_A);
		fetch(OP_PREFIX_ED);
		fetch(ED_IM2);
		fetch(OP_EI);
		idle;
		#1;
		chk("page", 8'h5A, int_page);
		irq(8'hA5);
		chk("acks", 16'h0004, acks);
		chk("addr", 16'h5AA5, irq_vector_addr);
		chk("indirect", 1'b1, irq_indirect);
	endtask
	task t_special;
		fetch(OP_PREFIX_ED);
		fetch(ED_LD_R_A);
		fetch(OP_PREFIX_ED);
		fetch(ED_LD_A_R);
		idle;
		#1;
		chk("rdvalid", 1'b1, special_read_valid);
		chk("rdrow", 8'h5B, special_read_data);
		fetch(OP_EI);
		fetch(OP_PREFIX_ED);
		fetch(ED_LD_A_I);
		idle;
		#1;
		chk("rdpage", 8'h5A, special_read_data);
		chk("enable", 1'b1, int_enable);
		exec(8'h00, 1'b0);
		chk("pv", 1'b1, flags[FLAG_PV]);
		fetch(OP_DI);
		idle;
		#1;
		chk("enable", 1'b0, int_enable);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		#(4000 * 50);
		mismatches++;
		conclude;
	end
	initial begin
		{rst_n, op_valid, exec_done, alu_ovf, raise, pop_flags_valid} = '0;
		{op_byte, alu_result, pop_flags, vec} = '0;
		acc_value  = 8'h5A;
		mismatches = 0;
		cmp_count  = 0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset;
		t_refresh;
		t_flags;
		t_int;
		t_special;
		conclude;
	end
endmodule
